// [pkg/scpd_pkg.sv]
// Package for the card presence detect block: register map, fields, timing.
// Assumes a 20 MHz system clock and an AXI4-Lite register bus.
package scpd_pkg;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_EN = 8'h08;
    localparam logic [7:0] ADDR_CLEAR  = 8'h0C;
    localparam logic [7:0] ADDR_LEVEL  = 8'h10;

    // Control fields
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_POL_BIT   = 1;
    localparam int CTRL_INS_BIT   = 2;
    localparam int CTRL_AREG_BIT  = 3;
    localparam int CTRL_FUNC_BIT  = 4;
    localparam int CTRL_CLASS_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;

    // Status / enable / clear fields
    localparam int EV_REMOVE_BIT = 0;
    localparam int EV_INSERT_BIT = 1;

    // Level register fields
    localparam int LVL_PRESENT_BIT = 0;
    localparam int LVL_RAW_BIT     = 1;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_HZ          = 20000000;
    localparam int INS_DEBOUNCE_US = 500;
    localparam int EXT_DEBOUNCE_US = 15000;
    localparam int INS_CYCLES = (CLK_HZ / 1000000) * INS_DEBOUNCE_US;
    localparam int EXT_CYCLES = (CLK_HZ / 1000000) * EXT_DEBOUNCE_US;

    typedef struct packed {
        logic enable;
        logic polarity_low;
        logic report_insert;
        logic auto_reg;
        logic full_func;
        logic low_volt_class;
    } scpd_ctrl_s;

    typedef struct packed {
        logic insert;
        logic remove;
    } scpd_ev_s;

endpackage

// [core/scpd_debounce.sv]
// Debounce filter with separate times towards each level.
// Assumes a synchronous input; restarts timing on any reversal.
`timescale 1ns/1ps
module scpd_debounce #(
    parameter int INS_CYCLES = 10000,
    parameter int EXT_CYCLES = 300000
) (
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    input  wire logic run,
    input  wire logic present_raw,
    output logic      present_q,
    output logic      rise_pulse,
    output logic      fall_pulse
);
    localparam int CW = $clog2(EXT_CYCLES + 1);

    logic [CW-1:0] cnt_q;
    logic          match;
    logic [CW-1:0] target;

    assign target = present_q ? CW'(EXT_CYCLES - 1) : CW'(INS_CYCLES - 1);
    assign match  = cnt_q == target;

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !run || present_raw == present_q) begin
            cnt_q <= '0;
        end else if (!match) begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !run) begin
            present_q <= 1'b0;
        end else if (present_raw != present_q && match) begin
            present_q <= present_raw;
        end
    end

    assign rise_pulse = run && present_raw && !present_q && match;
    assign fall_pulse = run && !present_raw && present_q && match;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_no_early_change;
        @(posedge clk_sys) disable iff (sys_rst)
        (run && $changed(present_q) && $past(run)) |->
            ($past(present_raw) == present_q);
    endproperty
    a_no_early_change: assert property (p_no_early_change)
        else $error("level accepted without matching input");

endmodule

// [core/scpd_top.sv]
// Card presence detect with AXI4-Lite registers and one interrupt.
// Assumes inputs synchronous to clk_sys; card protocol engine lies outside.
//
// How it works
// - Detection is off after reset; no events until software enables it.
// - Pull-up on detect input is enabled while detection is enabled.
// - Polarity bit picks present as driven low or as floating high.
// - Mode bit picks removal-only or removal-and-insertion reporting.
// - Auto-registration and functionality settings also gate the actions.
// - Debounced removal pulses the de-registration request.
// - Debounced insertion, when reported, pulses the re-registration request.
// - Detection runs regardless of the idle indication.
// - Insertion needs 0.5 ms of stable level.
// - Extraction needs 15 ms of stable level.
// - Class bit selects low-voltage or standard supply and levels.
// - Card clock divider is programmable to cover all protocol rates.
// - Drives supply, clock, reset, data line and senses detect input.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module scpd_top #(
    parameter int INS_CYCLES = scpd_pkg::INS_CYCLES,
    parameter int EXT_CYCLES = scpd_pkg::EXT_CYCLES
) (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        idle_mode,
    input  wire logic        card_detect_in,
    output logic             card_detect_pullup_en,
    output logic             card_supply_out,
    output logic             card_low_volt_sel,
    output logic             card_clock_out,
    output logic             card_reset_out,
    input  wire logic        card_data_io_in,
    output logic             card_data_io_out,
    output logic             card_data_io_oe,
    input  wire logic        card_reset_req,
    input  wire logic        card_data_tx,
    input  wire logic        card_data_drive_low,
    output logic             card_data_rx,
    input  wire logic [7:0]  card_clock_div,
    output logic             deregister_req,
    output logic             reregister_req,
    output logic             irq
);

    // ****************************************************************
    // Control and event state
    // ****************************************************************
    scpd_pkg::scpd_ctrl_s ctrl_q;
    scpd_pkg::scpd_ev_s   status_q;
    scpd_pkg::scpd_ev_s   irq_en_q;
    scpd_pkg::scpd_ev_s   set_ev;
    scpd_pkg::scpd_ev_s   clr_ev;
    logic                 present_raw;
    logic                 present_q;
    logic                 rise_pulse;
    logic                 fall_pulse;
    logic                 act_ok;
    logic                 dereg_q;
    logic                 rereg_q;

    // Idle does not gate the filter, so detection survives idle mode.
    assign card_detect_pullup_en = ctrl_q.enable;
    assign present_raw = ctrl_q.polarity_low ? !card_detect_in
                                             : card_detect_in;

    scpd_debounce #(
        .INS_CYCLES (INS_CYCLES),
        .EXT_CYCLES (EXT_CYCLES)
    ) u_debounce (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .run         (ctrl_q.enable),
        .present_raw (present_raw),
        .present_q   (present_q),
        .rise_pulse  (rise_pulse),
        .fall_pulse  (fall_pulse)
    );

    assign set_ev.remove = fall_pulse;
    assign set_ev.insert = rise_pulse && ctrl_q.report_insert;
    assign act_ok = ctrl_q.auto_reg && ctrl_q.full_func;

    // Set beats clear when both land in one cycle.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clr_ev) | set_ev;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            dereg_q <= 1'b0;
            rereg_q <= 1'b0;
        end else begin
            dereg_q <= set_ev.remove && act_ok;
            rereg_q <= set_ev.insert && act_ok;
        end
    end

    assign deregister_req = dereg_q;
    assign reregister_req = rereg_q;
    assign irq = |(status_q & irq_en_q);

    // ****************************************************************
    // Card pins
    // ****************************************************************
    logic [7:0] clk_cnt_q;
    logic       clk_q;
    logic       sup_q;

    // Supply only with a card seen; clock and reset held low and data line released otherwise.
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            sup_q <= 1'b0;
        end else begin
            sup_q <= present_q;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst || !sup_q) begin
            clk_cnt_q <= 8'h00;
            clk_q     <= 1'b0;
        end else if (clk_cnt_q >= card_clock_div) begin
            clk_cnt_q <= 8'h00;
            clk_q     <= !clk_q;
        end else begin
            clk_cnt_q <= clk_cnt_q + 8'h01;
        end
    end

    assign card_supply_out   = sup_q;
    assign card_low_volt_sel = ctrl_q.low_volt_class;
    assign card_clock_out    = clk_q;
    assign card_reset_out    = sup_q && !card_reset_req;
    // Open-drain data line: only ever pulled low.
    assign card_data_io_out  = 1'b0;
    assign card_data_io_oe   = sup_q && card_data_drive_low
                               && !card_data_tx;
    assign card_data_rx      = card_data_io_in;

    // ****************************************************************
    // AXI4-Lite write channel
    // ****************************************************************
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        do_write;
    logic        bvalid_q;
    logic [1:0]  bresp_q;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign do_write      = aw_hold_q && w_hold_q && !bvalid_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_hold_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    function automatic logic wr_known(input logic [7:0] a);
        wr_known = a == scpd_pkg::ADDR_CTRL || a == scpd_pkg::ADDR_IRQ_EN
                   || a == scpd_pkg::ADDR_CLEAR;
    endfunction

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= scpd_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known(aw_addr_q) ? scpd_pkg::RESP_OKAY
                                           : scpd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctrl_q   <= scpd_pkg::CTRL_RESET;
            irq_en_q <= '0;
        end else if (do_write && w_strb_q[0]) begin
            if (aw_addr_q == scpd_pkg::ADDR_CTRL) begin
                ctrl_q <= {w_data_q[scpd_pkg::CTRL_EN_BIT],
                           w_data_q[scpd_pkg::CTRL_POL_BIT],
                           w_data_q[scpd_pkg::CTRL_INS_BIT],
                           w_data_q[scpd_pkg::CTRL_AREG_BIT],
                           w_data_q[scpd_pkg::CTRL_FUNC_BIT],
                           w_data_q[scpd_pkg::CTRL_CLASS_BIT]};
            end else if (aw_addr_q == scpd_pkg::ADDR_IRQ_EN) begin
                irq_en_q <= {w_data_q[scpd_pkg::EV_INSERT_BIT],
                             w_data_q[scpd_pkg::EV_REMOVE_BIT]};
            end
        end
    end

    always_comb begin
        clr_ev = '0;
        if (do_write && w_strb_q[0] && aw_addr_q == scpd_pkg::ADDR_CLEAR) begin
            clr_ev = {w_data_q[scpd_pkg::EV_INSERT_BIT],
                      w_data_q[scpd_pkg::EV_REMOVE_BIT]};
        end
    end

    // ****************************************************************
    // AXI4-Lite read channel
    // ****************************************************************
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= scpd_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= scpd_pkg::RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
            if (s_axi_araddr == scpd_pkg::ADDR_CTRL) begin
                rdata_q[scpd_pkg::CTRL_EN_BIT]    <= ctrl_q.enable;
                rdata_q[scpd_pkg::CTRL_POL_BIT]   <= ctrl_q.polarity_low;
                rdata_q[scpd_pkg::CTRL_INS_BIT]   <= ctrl_q.report_insert;
                rdata_q[scpd_pkg::CTRL_AREG_BIT]  <= ctrl_q.auto_reg;
                rdata_q[scpd_pkg::CTRL_FUNC_BIT]  <= ctrl_q.full_func;
                rdata_q[scpd_pkg::CTRL_CLASS_BIT] <= ctrl_q.low_volt_class;
            end else if (s_axi_araddr == scpd_pkg::ADDR_STATUS) begin
                rdata_q[scpd_pkg::EV_REMOVE_BIT] <= status_q.remove;
                rdata_q[scpd_pkg::EV_INSERT_BIT] <= status_q.insert;
            end else if (s_axi_araddr == scpd_pkg::ADDR_IRQ_EN) begin
                rdata_q[scpd_pkg::EV_REMOVE_BIT] <= irq_en_q.remove;
                rdata_q[scpd_pkg::EV_INSERT_BIT] <= irq_en_q.insert;
            end else if (s_axi_araddr == scpd_pkg::ADDR_LEVEL) begin
                rdata_q[scpd_pkg::LVL_PRESENT_BIT] <= present_q;
                rdata_q[scpd_pkg::LVL_RAW_BIT]     <= present_raw;
            end else if (s_axi_araddr != scpd_pkg::ADDR_CLEAR) begin
                rresp_q <= scpd_pkg::RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_off_no_event;
        @(posedge clk_sys) disable iff (sys_rst)
        !ctrl_q.enable |-> ##1 !deregister_req && !reregister_req;
    endproperty
    a_off_no_event: assert property (p_off_no_event)
        else $error("event while detection disabled");

    property p_pullup;
        @(posedge clk_sys) disable iff (sys_rst)
        card_detect_pullup_en == ctrl_q.enable;
    endproperty
    a_pullup: assert property (p_pullup)
        else $error("pull-up does not follow enable");

    property p_no_insert_mode;
        @(posedge clk_sys) disable iff (sys_rst)
        (!ctrl_q.report_insert && rise_pulse) |=> !status_q.insert
            || $past(status_q.insert);
    endproperty
    a_no_insert_mode: assert property (p_no_insert_mode)
        else $error("insertion flagged in removal-only mode");

    property p_dereg;
        @(posedge clk_sys) disable iff (sys_rst)
        (fall_pulse && act_ok) |=> deregister_req ##1 !deregister_req;
    endproperty
    a_dereg: assert property (p_dereg)
        else $error("removal did not pulse de-registration");

    property p_rereg_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        reregister_req |-> $past(ctrl_q.report_insert && act_ok);
    endproperty
    a_rereg_gate: assert property (p_rereg_gate)
        else $error("re-registration without qualifying settings");

    property p_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        (status_q.remove && clr_ev.remove == 1'b0) |=> status_q.remove;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("removal flag dropped without acknowledge");

    property p_set_wins;
        @(posedge clk_sys) disable iff (sys_rst)
        set_ev.remove |=> status_q.remove;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("removal event lost");

    property p_irq;
        @(posedge clk_sys) disable iff (sys_rst)
        (status_q.insert && irq_en_q.insert) |-> irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("enabled flag without interrupt");

endmodule

// [testbench/scpd_card_model.sv]
// Card holder model: detect switch and open-drain data line.
// Assumes the bench moves inserted and contact_low just after clock edges.
`timescale 1ns/1ps
module scpd_card_model (
    input  wire logic clk_sys,
    input  wire logic inserted,
    input  wire logic contact_low,
    input  wire logic pullup_en,
    input  wire logic data_oe,
    input  wire logic card_pull_low,
    output logic      detect_pin,
    output logic      data_line
);
    logic float_q = 1'b0;
    logic pin_low;

    // ************************************************************
    // Detect switch
    // ************************************************************
    // Unpulled open pin toggles, so no stale level can pass as valid
    always_ff @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // Present card grounds the pin, or an empty holder grounds it
    assign pin_low = contact_low ? inserted : ~inserted;
    assign detect_pin = pin_low ? 1'b0 : (pullup_en ? 1'b1 : float_q);

    // ************************************************************
    // Data line, pulled up at the card side
    // ************************************************************
    assign data_line = ~(data_oe | (inserted & card_pull_low));
endmodule

// [testbench/scpd_top_tb_top.sv]
// Self-checking bench for the card presence detect block.
// Assumes shortened debounce counts and the card model at the detect pin.
`timescale 1ns/1ps
module scpd_top_tb_top;
    localparam int INS = 8;
    localparam int EXT = 20;
    localparam logic [1:0] OK = scpd_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = scpd_pkg::RESP_SLVERR;
    localparam logic [7:0] CTRL = scpd_pkg::ADDR_CTRL;
    localparam logic [7:0] STAT = scpd_pkg::ADDR_STATUS;
    localparam logic [7:0] IEN = scpd_pkg::ADDR_IRQ_EN;
    localparam logic [7:0] CLR = scpd_pkg::ADDR_CLEAR;
    localparam logic [7:0] LVL = scpd_pkg::ADDR_LEVEL;
    typedef struct {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [1:0]  bresp;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } scpd_row_s;
    logic        clk_sys = 1'b0;
    logic        sys_rst;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, card_clock_div;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, idle_mode, card_detect_in;
    logic        card_detect_pullup_en, card_supply_out, card_low_volt_sel;
    logic        card_clock_out, card_reset_out, card_data_io_in;
    logic        card_data_io_out, card_data_io_oe, card_reset_req;
    logic        card_data_tx, card_data_drive_low, card_data_rx;
    logic        deregister_req, reregister_req, irq;
    logic        inserted, contact_low, card_pull_low;
    int          num_errors = 0;
    int          n_checks = 0;
    int          at, nt;
    logic        ck;
    scpd_row_s   rows [5];

    always #25 clk_sys = ~clk_sys;

    scpd_top #(.INS_CYCLES(INS), .EXT_CYCLES(EXT)) i_scpd_top (
        .clk_sys, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .idle_mode, .card_detect_in,
        .card_detect_pullup_en, .card_supply_out, .card_low_volt_sel,
        .card_clock_out, .card_reset_out, .card_data_io_in,
        .card_data_io_out, .card_data_io_oe, .card_reset_req,
        .card_data_tx, .card_data_drive_low, .card_data_rx,
        .card_clock_div, .deregister_req, .reregister_req, .irq);

    scpd_card_model i_scpd_card_model (
        .clk_sys(clk_sys), .inserted(inserted), .contact_low(contact_low),
        .pullup_en(card_detect_pullup_en), .data_oe(card_data_io_oe),
        .card_pull_low(card_pull_low), .detect_pin(card_detect_in),
        .data_line(card_data_io_in));

    // ************************************************************
    // Checking and bus tasks
    // ************************************************************
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask

    task automatic hang(input string nm);
        $display("wrong value %s expected answer seen timeout", nm);
        num_errors++;
        report_and_stop();
    endtask

    // Leading edge keeps a release and a new request apart
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                resp = s_axi_bresp;
                s_axi_bready <= 1'b0;
                return;
            end
        end
        hang("bvalid");
    endtask

    task automatic rdr(input logic [7:0] a);
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                resp = s_axi_rresp;
                s_axi_rready <= 1'b0;
                return;
            end
        end
        hang("rvalid");
    endtask

    // First cycle of a request pulse within n cycles, or -1
    task automatic watch(input bit re, input int n, output int pos);
        pos = -1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk_sys);
            if ((re ? reregister_req : deregister_req) === 1'b1 && pos < 0)
                pos = i;
        end
    endtask

    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        sys_rst = 1'b1;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, idle_mode, card_reset_req} = '0;
        {card_data_tx, card_data_drive_low, card_pull_low} = '0;
        {inserted, contact_low} = 2'h1;
        s_axi_wstrb = 4'hF;
        card_clock_div = 8'h03;
        rows = '{'{IEN, 32'h3, OK, 32'h3, OK},
                 '{CTRL, 32'h20, OK, 32'h20, OK},
                 '{STAT, 32'h3, ERR, 32'h0, OK},
                 '{CLR, 32'h3, OK, 32'h0, OK},
                 '{8'h40, 32'h1, ERR, 32'h0, ERR}};
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        foreach (rows[k]) begin
            wr(rows[k].addr, rows[k].wdata);
            chk("bresp", rows[k].bresp, resp);
            rdr(rows[k].addr);
            chk("rdata", rows[k].rdata, rd);
            chk("rresp", rows[k].rresp, resp);
        end
        chk("low_volt_sel", 1, card_low_volt_sel);
        // Second reset with a card already seated
        inserted <= 1'b1;
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rdr(CTRL);
        chk("ctrl", 0, rd);
        chk("low_volt_sel", 0, card_low_volt_sel);
        chk("pullup", 0, card_detect_pullup_en);
        watch(1, 40, at);
        chk("reregister", -1, at);
        rdr(STAT);
        chk("status", 0, rd);
        wr(IEN, 32'h3);
        idle_mode <= 1'b1;
        wr(CTRL, 32'h1F);
        watch(1, INS + 6, at);
        chk("insert time", 1, at >= INS - 3 && at <= INS + 3);
        chk("pullup", 1, card_detect_pullup_en);
        chk("supply", 1, card_supply_out);
        chk("reset_out", 1, card_reset_out);
        // Divider 3: a toggle every 4 cycles, so 2 in any 8
        nt = 0;
        for (int i = 0; i < 8; i++) begin
            ck = card_clock_out;
            @(posedge clk_sys);
            if (ck !== card_clock_out)
                nt++;
        end
        chk("clock toggles", 2, nt);
        card_reset_req <= 1'b1;
        @(posedge clk_sys);
        chk("reset_out", 0, card_reset_out);
        card_reset_req <= 1'b0;
        chk("irq", 1, irq);
        rdr(STAT);
        chk("status", 32'h2, rd);
        card_data_drive_low <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("data_oe", 1, card_data_io_oe);
        chk("data_rx", 0, card_data_rx);
        @(posedge clk_sys);
        card_data_tx <= 1'b1;
        card_pull_low <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1 chk("data_oe", 0, card_data_io_oe);
        chk("data_rx", 0, card_data_rx);
        @(posedge clk_sys);
        card_pull_low <= 1'b0;
        card_data_drive_low <= 1'b0;
        card_data_tx <= 1'b0;
        inserted <= 1'b0;
        watch(0, EXT - 4, at);
        inserted <= 1'b1;
        chk("deregister", -1, at);
        chk("data_rx", 1, card_data_rx);
        chk("data_out", 0, card_data_io_out);
        watch(0, EXT + 6, at);
        chk("deregister", -1, at);
        wr(CLR, 32'h2);
        rdr(STAT);
        chk("status", 0, rd);
        chk("irq", 0, irq);
        @(posedge clk_sys);
        inserted <= 1'b0;
        watch(0, EXT + 6, at);
        chk("remove time", 1, at >= EXT - 2 && at <= EXT + 3);
        chk("irq", 1, irq);
        wr(IEN, 32'h0);
        chk("irq masked", 0, irq);
        wr(IEN, 32'h1);
        chk("irq", 1, irq);
        wr(CLR, 32'h1);
        chk("irq cleared", 0, irq);
        // Removal-only mode, then no auto-registration
        wr(CTRL, 32'h1B);
        inserted <= 1'b1;
        watch(1, INS + 6, at);
        chk("reregister", -1, at);
        rdr(LVL);
        chk("level", 1, rd[scpd_pkg::LVL_PRESENT_BIT]);
        wr(CTRL, 32'h17);
        inserted <= 1'b0;
        watch(0, EXT + 6, at);
        chk("deregister", -1, at);
        rdr(STAT);
        chk("status", 32'h1, rd);
        // Other polarity: present card leaves the pin floating high
        wr(CTRL, 32'h0);
        contact_low <= 1'b0;
        inserted <= 1'b1;
        wr(CTRL, 32'h1D);
        watch(1, INS + 6, at);
        chk("insert time", 1, at >= INS - 3 && at <= INS + 3);
        report_and_stop();
    end
endmodule
